// >>> glp_pkg.sv
// Package for the pin 2 low-level PWM block: register map, fields, reset values, time-base codes.
// Assumes a single 50 MHz master clock and an AHB-Lite register bus with 32-bit data.
package glp_pkg;

   // ********************************************************
   // Register map
   // ********************************************************
   // Printed offset 53h is not a multiple of four, so it is an index; byte address is four times it
   localparam logic [7:0]  GLP_CFG_INDEX     = 8'h53;
   localparam logic [9:0]  GLP_CFG_ADDR      = 10'h14c;
   localparam logic [15:0] GLP_CFG_RESET     = 16'h007f;
   localparam logic [9:0]  GLP_STATUS_ADDR   = 10'h150;

   // ********************************************************
   // Field layout
   // ********************************************************
   localparam int GLP_TB_MSB = 15;
   localparam int GLP_TB_LSB = 14;
   localparam int GLP_HC_MSB = 13;
   localparam int GLP_HC_LSB = 7;
   localparam int GLP_LC_MSB = 6;
   localparam int GLP_LC_LSB = 0;

   // ********************************************************
   // Time base
   // ********************************************************
   localparam logic [1:0]  GLP_TB_16    = 2'h0;
   localparam logic [1:0]  GLP_TB_64    = 2'h1;
   localparam logic [1:0]  GLP_TB_1024  = 2'h2;
   localparam logic [9:0]  GLP_DIV_16   = 10'h00f;
   localparam logic [9:0]  GLP_DIV_64   = 10'h03f;
   localparam logic [9:0]  GLP_DIV_1024 = 10'h3ff;

   typedef struct packed {
      logic [1:0] time_base;
      logic [6:0] high_count;
      logic [6:0] low_count;
   } glp_cfg_s;

   typedef enum logic [1:0] {
      GLP_ST_STATIC_LOW  = 2'b00,
      GLP_ST_STATIC_HIGH = 2'b01,
      GLP_ST_HIGH        = 2'b10,
      GLP_ST_LOW         = 2'b11
   } glp_state_e;

endpackage

// >>> glp_time_base.sv
// Time-base divider: one-cycle tick every 16, 64 or 1024 master clock periods.
// Assumes the select comes from a register on the same clock.
`timescale 1ns/1ps
`default_nettype none
module glp_time_base
(
   input  wire  logic       hclk,
   input  wire  logic       hresetn,
   input  wire  logic [1:0] sel,
   output logic             tick
);
   import glp_pkg::*;

   logic [9:0] cnt_reg;
   logic [9:0] limit;

   // ********************************************************
   // Divider
   // ********************************************************
   always_comb
   begin
      unique case (sel)
         GLP_TB_16: limit = GLP_DIV_16;
         GLP_TB_64: limit = GLP_DIV_64;
         default:   limit = GLP_DIV_1024;
      endcase
   end

   // A select change mid-count restarts cleanly once the count passes the new limit
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_reg <= 10'h000;
         tick    <= 1'b0;
      end
      else if (cnt_reg >= limit)
      begin
         cnt_reg <= 10'h000;
         tick    <= 1'b1;
      end
      else
      begin
         cnt_reg <= cnt_reg + 10'h001;
         tick    <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// >>> glp_pwm.sv
// Pin 2 low-level PWM generator with its configuration register on AHB-Lite.
// Assumes one slave on a single-master AHB-Lite bus, word transfers only.
//
// How it works
// - A 2-bit time-base select sets the PWM unit, also offered to the encoder.
// - Codes 00b, 01b, 10b/11b give 16, 64, 1024 master clock periods.
// - Bits 13:7 hold the high count for the logic-high state.
// - Period equals high plus low count times the time-base unit.
// - High time equals high count times the time-base unit.
// - High count zero gives a static low output.
// - Both counts zero gives a static low output.
// - Configuration register at index 53h resets to 007Fh.
// - Low time equals low count (bits 6:0) times the time-base unit.
// - Low count zero with a nonzero high count gives a static high output.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module glp_pwm
(
   input  wire  logic        hclk,
   input  wire  logic        hresetn,
   input  wire  logic        hsel,
   input  wire  logic [31:0] haddr,
   input  wire  logic [1:0]  htrans,
   input  wire  logic        hwrite,
   input  wire  logic [2:0]  hsize,
   input  wire  logic [31:0] hwdata,
   input  wire  logic        hready,
   output logic [31:0]       hrdata,
   output logic              hreadyout,
   output logic              hresp,
   output logic              pwm_out,
   output logic              time_base_tick
);
   import glp_pkg::*;

   glp_cfg_s   cfg_reg;
   glp_state_e state_reg;
   logic [6:0] count_reg;
   logic       wr_pend_reg;
   logic       rd_pend_reg;
   logic [9:0] addr_reg;
   logic       tick;

   // ********************************************************
   // Bus slave
   // ********************************************************
   // Zero-wait slave: address phase latched, data phase completes next cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 10'h000;
      end
      else if (hready)
      begin
         wr_pend_reg <= hsel && htrans[1] && hwrite;
         rd_pend_reg <= hsel && htrans[1] && !hwrite;
         addr_reg    <= haddr[9:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cfg_reg <= GLP_CFG_RESET;
      else if (wr_pend_reg && addr_reg == GLP_CFG_ADDR)
         cfg_reg <= hwdata[15:0];
   end

   // Read data registered in the address phase so hrdata comes from a flip-flop
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (hready && hsel && htrans[1] && !hwrite)
      begin
         if (haddr[9:0] == GLP_CFG_ADDR)
            hrdata <= {16'h0000, cfg_reg};
         else if (haddr[9:0] == GLP_STATUS_ADDR)
            hrdata <= {22'h000000, count_reg, state_reg, pwm_out};
         else
            hrdata <= 32'h0000_0000;
      end
   end

   // ********************************************************
   // Time base
   // ********************************************************
   glp_time_base u_time_base
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .sel     (cfg_reg.time_base),
      .tick    (tick)
   );

   // The encoder shares the same unit
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         time_base_tick <= 1'b0;
      else
         time_base_tick <= tick;
   end

   // ********************************************************
   // Waveform
   // ********************************************************
   // Counts are sampled at phase starts, so a new nonzero count takes effect at the next phase; a zero count forces a static state next cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg <= GLP_ST_STATIC_LOW;
         count_reg <= 7'h00;
      end
      else if (cfg_reg.high_count == 7'h00)
      begin
         state_reg <= GLP_ST_STATIC_LOW;
         count_reg <= 7'h00;
      end
      else if (cfg_reg.low_count == 7'h00)
      begin
         state_reg <= GLP_ST_STATIC_HIGH;
         count_reg <= 7'h00;
      end
      else
      begin
         unique case (state_reg)
            GLP_ST_STATIC_LOW, GLP_ST_STATIC_HIGH:
            begin
               state_reg <= GLP_ST_HIGH;
               count_reg <= cfg_reg.high_count;
            end
            GLP_ST_HIGH:
               if (tick)
               begin
                  if (count_reg == 7'h01)
                  begin
                     state_reg <= GLP_ST_LOW;
                     count_reg <= cfg_reg.low_count;
                  end
                  else
                     count_reg <= count_reg - 7'h01;
               end
            GLP_ST_LOW:
               if (tick)
               begin
                  if (count_reg == 7'h01)
                  begin
                     state_reg <= GLP_ST_HIGH;
                     count_reg <= cfg_reg.high_count;
                  end
                  else
                     count_reg <= count_reg - 7'h01;
               end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pwm_out <= 1'b0;
      else
         pwm_out <= (state_reg == GLP_ST_HIGH) || (state_reg == GLP_ST_STATIC_HIGH);
   end

endmodule
`default_nettype wire

// >>> glp_load_model.sv
// Load on the pin: keeps the length of the last whole high and low runs.
// Assumes the pin is sampled on the master clock.
`timescale 1ns/1ps
`default_nettype none
module glp_load_model
(
   input  wire logic        hclk,
   input  wire logic        pin,
   output logic [15:0]      hi_len,
   output logic [15:0]      lo_len
);
   logic [15:0] run;
   logic        last;
   initial
   begin
      run = 16'h0;
      last = 1'b0;
      hi_len = 16'h0;
      lo_len = 16'h0;
   end
   // A run is counted only when it ends, so a cut first run is overwritten
   always @(posedge hclk)
   begin
      if (pin !== last)
      begin
         if (last)
            hi_len <= run;
         else
            lo_len <= run;
         run <= 16'h1;
         last <= pin;
      end
      else
         run <= run + 16'h1;
   end
endmodule
`default_nettype wire

// >>> glp_pwm_chk.sv
// Checker for the pin 2 low-level PWM block.
// Assumes it is bound to glp_pwm and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module glp_pwm_chk
   import glp_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   input  wire logic        hreadyout,
   input  wire logic        hresp,
   input  wire logic        pwm_out,
   input  wire logic        time_base_tick
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic rd;
   logic wr;
   assign rd = hsel && hready && htrans[1] && !hwrite;
   assign wr = hsel && hready && htrans[1] && hwrite;
   chk_ready_high: assert property (hreadyout == 1'b1) else $error("hreadyout low");
   chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
   chk_tick_gap:
      assert property (time_base_tick |=> (!time_base_tick) [*8]) else $error("ticks too close");
   chk_unmapped_zero: assert property (rd && haddr[9:0] != GLP_CFG_ADDR && haddr[9:0] != GLP_STATUS_ADDR
      |=> hrdata == 32'h0) else $error("unmapped read not zero");
   chk_cfg_upper:
      assert property (rd && haddr[9:0] == GLP_CFG_ADDR |=> hrdata[31:16] == 16'h0) else $error("upper bits set");
   chk_status_pin: assert property (rd && haddr[9:0] == GLP_STATUS_ADDR |=> hrdata[0] == $past(pwm_out))
      else $error("status pin bit wrong");
   chk_rdata_hold: assert property (!rd |=> $stable(hrdata)) else $error("hrdata moved");
   chk_pwm_cause:
      assert property ($changed(pwm_out) |-> $past(time_base_tick) || $past(time_base_tick, 2)
      || $past(wr, 2) || $past(wr, 3) || $past(wr, 4)) else $error("pwm edge without cause");
endmodule
`default_nettype wire

// >>> glp_pwm_tb.sv
// Testbench for the pin 2 low-level PWM block.
// Assumes a 50 MHz clock and the one slave on AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module glp_pwm_tb;
   import glp_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pwm_out, tick;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] hi_len, lo_len;
   int          n_fail, checks, gap;
   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   glp_pwm dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pwm_out(pwm_out), .time_base_tick(tick));
   glp_load_model load (.hclk(hclk), .pin(pwm_out), .hi_len(hi_len), .lo_len(lo_len));
   task automatic end_of_test;
      if (n_fail == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Single word transfer; waits on hready, no cycle count assumed
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   function automatic logic [31:0] cfg(input int t, input int hc, input int lc);
      return {16'h0, 2'(t), 7'(hc), 7'(lc)};
   endfunction
   function automatic logic [31:0] unit(input int t);
      return (t == 0) ? 32'h10 : (t == 1) ? 32'h40 : 32'h400;
   endfunction
   initial
   begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      n_fail = 0;
      checks = 0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, 32'(GLP_CFG_ADDR), 32'h0, q);
      chk(q, 32'(GLP_CFG_RESET));
      repeat (40) @(posedge hclk);
      chk({31'h0, pwm_out}, 32'h0);
      bus(1'b0, 32'h3fc, 32'h0, q);
      chk(q, 32'h0);
      bus(1'b1, 32'(GLP_CFG_ADDR), 32'h0, q);
      repeat (40) @(posedge hclk);
      chk({31'h0, pwm_out}, 32'h0);
      bus(1'b1, 32'(GLP_CFG_ADDR), cfg(0, 3, 0), q);
      repeat (40) @(posedge hclk);
      chk({31'h0, pwm_out}, 32'h1);
      bus(1'b0, 32'(GLP_STATUS_ADDR), 32'h0, q);
      chk(q, {22'h0, 7'h00, GLP_ST_STATIC_HIGH, 1'b1});
      for (int t = 0; t < 4; t++)
      begin
         bus(1'b1, 32'(GLP_CFG_ADDR), cfg(t, 2, 3), q);
         bus(1'b0, 32'(GLP_CFG_ADDR), 32'h0, q);
         chk(q, cfg(t, 2, 3));
         repeat (16 * unit(t)) @(posedge hclk);
         chk({16'h0, hi_len}, 2 * unit(t));
         chk({16'h0, lo_len}, 3 * unit(t));
         chk({16'h0, hi_len} + {16'h0, lo_len}, 5 * unit(t));
         // Encoder tick spacing must equal the selected unit
         do @(posedge hclk); while (tick !== 1'b1);
         gap = 0;
         do
         begin
            @(posedge hclk);
            gap++;
         end
         while (tick !== 1'b1);
         chk(32'(gap), unit(t));
      end
      end_of_test;
   end
   initial
   begin
      #1000000;
      n_fail++;
      end_of_test;
   end
endmodule
bind glp_pwm glp_pwm_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .pwm_out(pwm_out), .time_base_tick(time_base_tick));
`default_nettype wire
